// ### hw/dct_pkg.sv
// Purpose: shared constants and types for the debug comparator / trace count block
// Assumes: 32-bit AHB-Lite register window, 16-bit cpu address bus
// Notes:   all state except the reset synchronizer travels as one packed struct
package dct_pkg;
   // register byte offsets
   localparam logic [7:0] DCT_OFS_CTRL   = 8'h00;
   localparam logic [7:0] DCT_OFS_SEQ    = 8'h04;
   localparam logic [7:0] DCT_OFS_STATUS = 8'h08;
   localparam logic [7:0] DCT_OFS_COUNT  = 8'h0c;
   localparam logic [7:0] DCT_OFS_CMP_A  = 8'h10;
   localparam logic [7:0] DCT_OFS_CMP_B  = 8'h14;
   localparam logic [7:0] DCT_OFS_CMP_C  = 8'h18;
   // field positions
   localparam int DCT_BIT_ARM   = 7;
   localparam int DCT_BIT_ALIGN = 6;
   localparam int DCT_BIT_SOFTWARE_TRIGGER  = 7;
   localparam int DCT_CMP_W     = 22;
   // values
   localparam logic [5:0] DCT_CNT_RST    = 6'h00;
   localparam logic [5:0] DCT_CNT_MAX    = 6'h3f;
   localparam logic [5:0] DCT_NXT_RST    = 6'h3f;
   localparam logic [1:0] DCT_NXT_FINAL  = 2'h3;
   localparam logic [2:0] DCT_HSIZE_WORD = 3'h2;
   localparam int         DCT_CNT_W      = 6;

   typedef enum logic [4:0] {
      DCT_S0 = 5'b00001,
      DCT_S1 = 5'b00010,
      DCT_S2 = 5'b00100,
      DCT_S3 = 5'b01000,
      DCT_SF = 5'b10000
   } dct_seq_type;

   // bit order matches the comparator register, addr in [15:0]
   typedef struct packed {
      logic        en;
      logic        tag;
      logic        sz;
      logic        size_enable;
      logic        direction_enable;
      logic        rw;
      logic [15:0] addr;
   } dct_cmp_type;

   typedef struct packed {
      logic        valid;
      logic        rd;
      logic        word;
      logic [15:0] addr;
   } dct_bus_type;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } dct_exec_type;

   typedef struct packed {
      logic                  arm;
      logic                  align;
      logic [5:0]            nxt;
      dct_cmp_type [2:0]     cmp;
      dct_seq_type           seq;
      logic                  full;
      logic [DCT_CNT_W-1:0]  count;
      logic [2:0]            match;
      logic [31:0]           hrdata;
      logic                  hready;
      logic                  hresp;
      logic                  dp_valid;
      logic                  dp_write;
      logic [7:0]            dp_addr;
   } dct_state_type;

   localparam dct_state_type DCT_STATE_RST = '{
      arm: 1'b0, align: 1'b0, nxt: DCT_NXT_RST, cmp: '0, seq: DCT_S0,
      full: 1'b0, count: DCT_CNT_RST, match: 3'h0, hrdata: 32'h0,
      hready: 1'b1, hresp: 1'b0, dp_valid: 1'b0, dp_write: 1'b0, dp_addr: 8'h00};
endpackage : dct_pkg

// ### hw/dct_top.sv
// Purpose: debug comparators, match priority, state sequencer and trace line count
// Assumes: cpu bus and opcode tracker inputs synchronous to mclk; zero-wait AHB-Lite slave
// Notes:   nrst is the power-on reset; sys_reset is any other system reset
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module dct_top
   import dct_pkg::*;
#(
   parameter int TRACE_DEPTH = 64
) (
   // clock, power-on reset and system reset
   input  wire  logic                 mclk,
   input  wire  logic                 nrst,
   input  wire  logic                 sys_reset,
   // ahb-lite slave
   input  wire  logic                 hsel,
   input  wire  logic [31:0]          haddr,
   input  wire  logic [1:0]           htrans,
   input  wire  logic                 hwrite,
   input  wire  logic [2:0]           hsize,
   input  wire  logic [31:0]          hwdata,
   input  wire  logic                 hready,
   output logic       [31:0]          hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // cpu side
   input  wire  dct_pkg::dct_bus_type  cpu_bus,
   input  wire  dct_pkg::dct_exec_type op_exec,
   input  wire  logic                 trace_store,
   // observation
   output logic       [2:0]           match_out,
   output logic       [4:0]           seq_state,
   output logic                       armed,
   output logic                       buffer_full_flag,
   output logic       [5:0]           line_count
);
   if (TRACE_DEPTH != (1 << DCT_CNT_W)) begin : g_depth_chk
      $error("TRACE_DEPTH must equal 64");
   end

   dct_state_type r_reg;
   dct_state_type r_next;
   logic [1:0]    rst_sync_reg;
   logic          rst_n;
   logic          wr_now;
   logic          arm_wr;
   logic          disarm_wr;
   logic          software_trigger_wr;
   logic          store_ok;
   logic          ap_take;
   logic [2:0]    raw;
   logic          hit;
   logic [1:0]    tgt;
   logic [1:0]    nxt0;

   // only the second flop is used downstream
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   function automatic logic cmp_match(dct_cmp_type c, dct_bus_type b, dct_exec_type e,
                                      logic sized);
      logic dir_ok;
      logic size_ok;
      dir_ok  = !c.direction_enable || (c.rw == b.rd);
      size_ok = !sized || !c.size_enable || (c.sz == b.word);
      if (!c.en) begin
         cmp_match = 1'b0;
      end else if (c.tag) begin
         cmp_match = e.valid && (e.addr == c.addr);
      end else begin
         cmp_match = b.valid && (b.addr == c.addr) && dir_ok && size_ok;
      end
   endfunction : cmp_match

   function automatic dct_seq_type nxt_to_seq(logic [1:0] code);
      case (code)
         2'h0:    nxt_to_seq = DCT_S1;
         2'h1:    nxt_to_seq = DCT_S2;
         2'h2:    nxt_to_seq = DCT_S3;
         default: nxt_to_seq = DCT_SF;
      endcase
   endfunction : nxt_to_seq

   function automatic logic [2:0] seq_flags(dct_seq_type s);
      case (s)
         DCT_S1:  seq_flags = 3'h1;
         DCT_S2:  seq_flags = 3'h2;
         DCT_S3:  seq_flags = 3'h3;
         DCT_SF:  seq_flags = 3'h4;
         default: seq_flags = 3'h0;
      endcase
   endfunction : seq_flags

   function automatic logic [31:0] read_reg(dct_state_type s, logic [7:0] a);
      case (a)
         DCT_OFS_CTRL:   read_reg = {24'h0, s.arm, s.align, 6'h00};
         DCT_OFS_SEQ:    read_reg = {26'h0, s.nxt};
         DCT_OFS_STATUS: read_reg = {24'h0, s.full, 4'h0, seq_flags(s.seq)};
         DCT_OFS_COUNT:  read_reg = {24'h0, s.full, 1'b0, s.count};
         DCT_OFS_CMP_A:  read_reg = {10'h0, s.cmp[0]};
         DCT_OFS_CMP_B:  read_reg = {10'h0, s.cmp[1]};
         DCT_OFS_CMP_C:  read_reg = {10'h0, s.cmp[2]};
         default:        read_reg = 32'h0;
      endcase
   endfunction : read_reg

   always_comb begin
      r_next    = r_reg;
      wr_now    = r_reg.dp_valid && r_reg.dp_write;
      arm_wr    = wr_now && (r_reg.dp_addr == DCT_OFS_CTRL) && hwdata[DCT_BIT_ARM];
      disarm_wr = wr_now && (r_reg.dp_addr == DCT_OFS_CTRL) && !hwdata[DCT_BIT_ARM];
      software_trigger_wr   = wr_now && (r_reg.dp_addr == DCT_OFS_SEQ) && hwdata[DCT_BIT_SOFTWARE_TRIGGER];
      store_ok  = trace_store && r_reg.arm;
      ap_take   = hsel && htrans[1] && hready && (hsize == DCT_HSIZE_WORD);
      hit       = 1'b0;
      tgt       = 2'h0;
      // matches are per-cycle events, nothing is latched for a recheck
      for (int i = 0; i < 3; i++) begin
         raw[i] = cmp_match(r_reg.cmp[i], cpu_bus, op_exec, i < 2);
      end
      r_next.match = raw;

      // register writes; the count register is not writable
      if (wr_now) begin
         case (r_reg.dp_addr)
            DCT_OFS_CTRL:  r_next.align  = hwdata[DCT_BIT_ALIGN];
            DCT_OFS_SEQ:   r_next.nxt    = hwdata[5:0];
            DCT_OFS_CMP_A: r_next.cmp[0] = hwdata[DCT_CMP_W-1:0];
            DCT_OFS_CMP_B: r_next.cmp[1] = hwdata[DCT_CMP_W-1:0];
            DCT_OFS_CMP_C: r_next.cmp[2] = hwdata[DCT_CMP_W-1:0];
            default: ;
         endcase
      end

      // lowest channel wins, then any channel aiming at final overrides it
      if (r_reg.seq == DCT_S1 || r_reg.seq == DCT_S2 || r_reg.seq == DCT_S3) begin
         for (int i = 2; i >= 0; i--) begin
            if (raw[i]) begin
               hit = 1'b1;
               tgt = r_reg.nxt[2*i +: 2];
            end
         end
         for (int i = 2; i >= 0; i--) begin
            if (raw[i] && (r_reg.nxt[2*i +: 2] == DCT_NXT_FINAL)) begin
               tgt = DCT_NXT_FINAL;
            end
         end
         if (hit) begin
            r_next.seq = nxt_to_seq(tgt);
         end
      end
      // final state lasts one cycle then the session closes
      if (r_reg.seq == DCT_SF) begin
         r_next.seq = DCT_S0;
         r_next.arm = 1'b0;
      end
      if (software_trigger_wr && r_reg.arm) begin
         r_next.seq = DCT_SF;
      end
      if (disarm_wr) begin
         r_next.arm = 1'b0;
         r_next.seq = DCT_S0;
      end

      // trace line count; trace buffer reads have no path here
      if (store_ok) begin
         r_next.count = r_reg.count + 6'h01;
         if (r_reg.count == DCT_CNT_MAX) begin
            r_next.full = 1'b1;
            if (r_reg.align) begin
               r_next.arm = 1'b0;
               r_next.seq = DCT_S0;
            end
         end
      end
      if (arm_wr) begin
         r_next.arm   = 1'b1;
         r_next.seq   = DCT_S1;
         r_next.count = DCT_CNT_RST;
         r_next.full  = 1'b0;
      end

      // other resets restore control but spare the trace history
      if (sys_reset) begin
         r_next       = '{arm: 1'b0, align: 1'b0, nxt: DCT_NXT_RST, cmp: '0, seq: DCT_S0,
                          full: r_next.full, count: r_next.count, match: 3'h0,
                          hrdata: 32'h0, hready: 1'b1, hresp: 1'b0, dp_valid: 1'b0,
                          dp_write: 1'b0, dp_addr: 8'h00};
      end

      // bus: read data comes from the updated copy, so a write just before is seen
      r_next.hready   = 1'b1;
      r_next.hresp    = 1'b0;
      r_next.dp_valid = ap_take;
      r_next.dp_write = hwrite;
      r_next.dp_addr  = haddr[7:0];
      r_next.hrdata   = (ap_take && !hwrite) ? read_reg(r_next, haddr[7:0]) : 32'h0;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         r_reg <= DCT_STATE_RST;
      end else if (!rst_n) begin
         r_reg <= DCT_STATE_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign hrdata           = r_reg.hrdata;
   assign hreadyout        = r_reg.hready;
   assign hresp            = r_reg.hresp;
   assign match_out        = r_reg.match;
   assign seq_state        = r_reg.seq;
   assign armed            = r_reg.arm;
   assign buffer_full_flag = r_reg.full;
   assign line_count       = r_reg.count;
   assign nxt0             = r_reg.nxt[1:0];

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_final_then_idle;
      ##1 (r_reg.seq == DCT_SF) ##1 (r_reg.seq == DCT_S0 && !r_reg.arm);
   endsequence

   sequence s_wrap_cond;
      store_ok && (r_reg.count == DCT_CNT_MAX) && !arm_wr && !sys_reset;
   endsequence

   chk_full_on_wrap: assert property (s_wrap_cond |=> r_reg.full && r_reg.count == 6'h00)
      else $error("full flag not set on count wrap");
   chk_end_keep_count: assert property (store_ok && !r_reg.align && r_reg.full && !arm_wr
      && !sys_reset |=> r_reg.count == $past(r_reg.count) + 6'h01 && r_reg.full)
      else $error("end mode count did not continue");
   chk_arm_clears: assert property (arm_wr && !sys_reset
      |=> r_reg.count == 6'h00 && !r_reg.full && r_reg.seq == DCT_S1)
      else $error("arm write did not clear count and flag");
   chk_sysrst_keeps: assert property (sys_reset && !store_ok && !arm_wr
      |=> $stable(r_reg.count) && $stable(r_reg.full))
      else $error("system reset disturbed trace count");
   chk_count_stable: assert property (!store_ok && !arm_wr |=> $stable(r_reg.count))
      else $error("count changed without a stored line");
   chk_begin_ends: assert property (s_wrap_cond and r_reg.align
      |=> !r_reg.arm && r_reg.seq == DCT_S0 && r_reg.full)
      else $error("begin alignment did not end session");
   chk_status_mirror: assert property (ap_take && !hwrite && haddr[7:0] == DCT_OFS_STATUS
      |=> hrdata[7] == r_reg.full && hrdata[2:0] == seq_flags(r_reg.seq))
      else $error("status read does not mirror flag and state");
   chk_software_trigger_final: assert property (software_trigger_wr && r_reg.arm && !arm_wr && !disarm_wr && !sys_reset
      |-> s_final_then_idle)
      else $error("software trigger did not pass through final");
   chk_match_prio: assert property (r_reg.seq == DCT_S1 && raw[0] && raw[1]
      && r_reg.nxt[3:2] != DCT_NXT_FINAL && !software_trigger_wr && !arm_wr && !disarm_wr && !store_ok
      && !(raw[2] && r_reg.nxt[5:4] == DCT_NXT_FINAL)
      && !sys_reset |=> r_reg.seq == nxt_to_seq($past(nxt0)))
      else $error("match 0 did not win over match 1");
   chk_match_direct: assert property (##1 match_out == $past(raw) || $past(sys_reset))
      else $error("match outputs not taken from comparators");

   // a one-hot slip would read as idle (flags 0) in the status state flags
   sequence s_in_session;
      r_reg.seq == DCT_S1 || r_reg.seq == DCT_S2 || r_reg.seq == DCT_S3;
   endsequence

   chk_seq_onehot: assert property ($onehot(r_reg.seq))
      else $error("sequencer state is not one-hot");

   chk_arm_tracks_state: assert property (r_reg.arm == (r_reg.seq != DCT_S0))
      else $error("arm bit and sequencer state disagree");

   chk_final_leaves: assert property (r_reg.seq == DCT_SF && !arm_wr && !software_trigger_wr
      |=> r_reg.seq == DCT_S0 && !r_reg.arm)
      else $error("final state did not return to disarmed");

   chk_final_wins: assert property (s_in_session and raw[2]
      && r_reg.nxt[5:4] == DCT_NXT_FINAL && !arm_wr && !disarm_wr && !sys_reset
      && !(store_ok && r_reg.align && r_reg.count == DCT_CNT_MAX)
      |=> r_reg.seq == DCT_SF)
      else $error("channel aiming at final did not win");

   chk_count_step: assert property (store_ok && !arm_wr
      |=> r_reg.count == $past(r_reg.count) + 6'h01)
      else $error("stored line not counted");

   chk_full_sticky: assert property (r_reg.full && !arm_wr |=> r_reg.full)
      else $error("full flag dropped without an arm write");

   chk_full_rise: assert property ($rose(r_reg.full) |-> r_reg.count == 6'h00)
      else $error("full flag rose away from a count wrap");

   // comparator qualification, checked one cycle after the bus sample
   chk_tag_waits_exec: assert property (r_reg.cmp[1].en && r_reg.cmp[1].tag
      && !op_exec.valid |=> !match_out[1])
      else $error("tagged comparator matched without execution");

   chk_c_ignores_size: assert property (r_reg.cmp[2].en && !r_reg.cmp[2].tag
      && !r_reg.cmp[2].direction_enable && cpu_bus.valid && cpu_bus.addr == r_reg.cmp[2].addr
      && !sys_reset |=> match_out[2])
      else $error("comparator c missed an exact address");

   chk_c_exact: assert property (r_reg.cmp[2].en && !r_reg.cmp[2].tag && cpu_bus.valid
      && cpu_bus.addr != r_reg.cmp[2].addr |=> !match_out[2])
      else $error("comparator c matched a different address");

   chk_off_quiet: assert property (!r_reg.cmp[0].en |=> !match_out[0])
      else $error("disabled comparator a raised a match");
endmodule : dct_top
`default_nettype wire

// ### testbench/dct_cpu_model.sv
// Purpose: cpu side partner: address bus accesses, opcode tracker, trace stores
// Assumes: driven from the bench through task calls, changes right after a clock edge
// Notes:   a released bus shows the inverse of its last value, not a stale copy
`timescale 1ns/10ps
`default_nettype none
module dct_cpu_model
   import dct_pkg::*;
(
   // clock
   input  wire logic                   mclk,
   // cpu bus and tracker
   output var  dct_pkg::dct_bus_type   cpu_bus,
   output var  dct_pkg::dct_exec_type  op_exec,
   output var  logic                   trace_store
);
   initial begin
      cpu_bus     = '0;
      op_exec     = '0;
      trace_store = 1'b0;
   end
   // the fetch address appears on the bus as it is, tag or not
   task access(input logic [15:0] a, input logic rd, input logic word);
      @(posedge mclk);
      cpu_bus <= '{valid: 1'b1, rd: rd, word: word, addr: a};
      @(posedge mclk);
      cpu_bus <= '{valid: 1'b0, rd: ~rd, word: ~word, addr: ~a};
      #1;
   endtask : access
   // tracker reports the exact opcode address at execution
   task exec(input logic [15:0] a);
      @(posedge mclk);
      op_exec <= '{valid: 1'b1, addr: a};
      @(posedge mclk);
      op_exec <= '{valid: 1'b0, addr: ~a};
      #1;
   endtask : exec
   // back to back stores, one per cycle
   task store(input int n);
      repeat (n) begin
         @(posedge mclk);
         trace_store <= 1'b1;
      end
      @(posedge mclk);
      trace_store <= 1'b0;
      #1;
   endtask : store
endmodule : dct_cpu_model
`default_nettype wire

// ### testbench/tb.sv
// Purpose: register and comparator tests of the debug comparator / trace count block
// Assumes: zero wait slave, one idle cycle between bus transfers
// Notes:   expectations come from the register layout, never from dut outputs
`timescale 1ns/10ps
`default_nettype none
module tb;
   import dct_pkg::*;
   logic         mclk, nrst, sys_reset, hsel, hwrite;
   logic [31:0]  haddr, hwdata, hrdata, r;
   logic [1:0]   htrans;
   logic [2:0]   hsize, match_out;
   logic         hreadyout, hresp, armed, buffer_full_flag;
   logic [4:0]   seq_state;
   logic [5:0]   line_count;
   dct_bus_type  cpu_bus;
   dct_exec_type op_exec;
   logic         trace_store;
   int           miscompares, cmp_count, cycles;

   dct_top #(.TRACE_DEPTH(64)) dut (.mclk(mclk), .nrst(nrst), .sys_reset(sys_reset),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .cpu_bus(cpu_bus), .op_exec(op_exec), .trace_store(trace_store),
      .match_out(match_out), .seq_state(seq_state), .armed(armed),
      .buffer_full_flag(buffer_full_flag), .line_count(line_count));
   dct_cpu_model u_cpu (.mclk(mclk), .cpu_bus(cpu_bus), .op_exec(op_exec),
      .trace_store(trace_store));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task tally_and_finish;
      $display("checks %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   // single word transfer; waits on hready, never a fixed count
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= DCT_HSIZE_WORD;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      r = hrdata;
      #1;
   endtask : ahb

   // one-cycle reset; por picks power-on reset over the other system reset
   task reset_pulse(input logic por);
      @(posedge mclk);
      nrst      <= !por;
      sys_reset <= !por;
      @(posedge mclk);
      nrst      <= 1'b1;
      sys_reset <= 1'b0;
      repeat (4) @(posedge mclk);
      #1;
   endtask : reset_pulse

   // cut a hang short
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   initial begin
      nrst = 1'b0; sys_reset = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0;
      hwdata = 32'h0; htrans = 2'b00; hsize = 3'h0;
      miscompares = 0; cmp_count = 0;
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      repeat (4) @(posedge mclk);
      ahb(0, 8'h0c, 32'h0); check(r, 32'h0);
      ahb(0, 8'h08, 32'h0); check(r, 32'h0);
      ahb(0, 8'h1c, 32'h0); check(r, 32'h0);
      ahb(1, 8'h00, 32'h80); check(seq_state, DCT_S1);
      ahb(0, 8'h08, 32'h0); check(r, 32'h1);
      u_cpu.store(63); check(line_count, 6'h3f);
      check(buffer_full_flag, 1'b0);
      u_cpu.store(1); check(buffer_full_flag, 1'b1);
      check(line_count, 6'h00);
      ahb(0, 8'h08, 32'h0); check(r[7], 1'b1);
      u_cpu.store(1); check(line_count, 6'h01);
      ahb(1, 8'h0c, 32'hff); ahb(0, 8'h0c, 32'h0); check(r, 32'h81);
      ahb(0, 8'h0c, 32'h0); check(r, 32'h81);
      reset_pulse(1'b0);
      u_cpu.store(2); check(line_count, 6'h01);
      check(buffer_full_flag, 1'b1);
      reset_pulse(1'b1); check(line_count, 6'h00);
      check(buffer_full_flag, 1'b0);
      ahb(1, 8'h00, 32'h80); u_cpu.store(2);
      ahb(1, 8'h00, 32'h80); check(line_count, 6'h00);
      check(buffer_full_flag, 1'b0);
      // begin alignment ends the session at the wrap
      ahb(1, 8'h00, 32'hc0); u_cpu.store(64); check(armed, 1'b0);
      check(seq_state, DCT_S0);
      check(buffer_full_flag, 1'b1);
      // next states: match0 s2, match1 s3, match2 s1
      ahb(1, 8'h04, 32'h09); ahb(1, 8'h10, 32'h0020_1234); ahb(1, 8'h18, 32'h0020_1234);
      ahb(1, 8'h00, 32'h80); check(buffer_full_flag, 1'b0);
      u_cpu.access(16'h1233, 1, 1); check(match_out, 3'b000);
      // an access at exactly 1234 hits a and c, as a word and as a byte
      u_cpu.access(16'h1234, 1, 1); check(match_out, 3'b101);
      u_cpu.access(16'h1234, 1, 0); check(match_out, 3'b101);
      check(seq_state, DCT_S2);
      ahb(1, 8'h10, 32'h0);
      for (int i = 0; i < 8; i++) begin
         ahb(1, 8'h18, 32'h0020_1234 | (32'(i[2:1]) << 16));
         u_cpu.access(16'h1234, i[0], 0);
         check(match_out[2], !i[2] || (i[1] == i[0]));
      end
      // word size on a and c; c has no size qualifier
      ahb(1, 8'h10, 32'h002c_3000); ahb(1, 8'h18, 32'h002c_3000);
      u_cpu.access(16'h3000, 1, 0); check(match_out, 3'b100);
      u_cpu.access(16'h3000, 1, 1); check(match_out, 3'b101);
      ahb(1, 8'h14, 32'h0033_4000);
      u_cpu.access(16'h4000, 1, 1); check(match_out[1], 1'b0);
      u_cpu.exec(16'h4000); check(match_out, 3'b010);
      // all three at once, channel c points to final
      ahb(1, 8'h04, 32'h39);
      for (int i = 0; i < 3; i++) ahb(1, 8'h10 + 8'(4 * i), 32'h0020_5000);
      ahb(1, 8'h00, 32'h80);
      u_cpu.access(16'h5000, 0, 0); check(match_out, 3'b111);
      check(seq_state, DCT_SF);
      @(posedge mclk); #1 check(armed, 1'b0);
      ahb(1, 8'h04, 32'h09); ahb(1, 8'h00, 32'h80);
      u_cpu.access(16'h5000, 0, 0); check(seq_state, DCT_S2);
      @(posedge mclk); #1 check(seq_state, DCT_S2);
      ahb(1, 8'h04, 32'h89); check(seq_state, DCT_SF);
      @(posedge mclk); #1 check(seq_state, DCT_S0);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
